// *** dv/fifo_device_model.sv ***
// behavioural model of the asynchronous strobe fifo device
// assumes strobes from the host; no clock at all
`timescale 1ns/10ps
module fifo_device_model #(parameter int DEPTH = 256) (
  input  wire [8:0] write_bus_i,      // nine bit words
  input  wire       store_strobe_n_i,
  input  wire       fetch_pulse_n_i,
  input  wire       clear_n_i,
  input  wire       replay_n_i,
  input  wire       chain_in_n_i,
  output wire [8:0] read_bus_o,
  output wire       empty_flag_n_o,
  output wire       full_flag_n_o,
  output wire       half_level_n_o
);
  logic [8:0] mem [DEPTH];      // storage ring
  logic [8:0] last_q = 9'h0a5;  // last word driven out
  int         wp = 5;           // pointers hold garbage until cleared
  int         rp = 0;
  bit         wok;              // write cycle allowed
  bit         rok;              // read cycle allowed
  always @(negedge clear_n_i) begin
    wp = 0;
    rp = 0;
  end
  always @(negedge store_strobe_n_i) wok = (wp - rp < DEPTH);
  always @(posedge store_strobe_n_i) begin
    if (wok) begin
      mem[wp % DEPTH] = write_bus_i;
      wp++;
    end
  end
  always @(negedge fetch_pulse_n_i) rok = (wp != rp);
  always @(posedge fetch_pulse_n_i) begin
    if (rok) begin
      last_q = mem[rp % DEPTH];
      rp++;
    end
  end
  always @(negedge replay_n_i) if (!chain_in_n_i) rp = 0;
  // released bus shows the inverse of the last word
  assign read_bus_o = (!fetch_pulse_n_i && rok) ? mem[rp % DEPTH] : ~last_q;
  assign empty_flag_n_o = (wp != rp);
  assign full_flag_n_o = (wp - rp != DEPTH);
  assign half_level_n_o = chain_in_n_i || (wp - rp <= DEPTH / 2);
endmodule // fifo_device_model

// *** dv/strobe_fifo_host_properties.sv ***
// checker for the device pins of the strobe fifo host
// assumes it is bound onto strobe_fifo_host
`timescale 1ns/10ps
module strobe_fifo_host_properties (
  input wire       clock_i,
  input wire       rst_i,
  input wire [8:0] write_bus_o,
  input wire       store_strobe_n_o,
  input wire       fetch_pulse_n_o,
  input wire       clear_n_o,
  input wire       replay_n_o,
  input wire       chain_in_n_o,
  input wire       empty_flag_n_i,
  input wire       full_flag_n_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ********************
  // clear seen since reset
  // ********************
  reg cleared_reg; // set once the device got a clear pulse
  always @(posedge clock_i) begin
    if (rst_i) cleared_reg <= 1'b0;
    else if (!clear_n_o) cleared_reg <= 1'b1;
  end
  clear_quiet_a: assert property (!clear_n_o |-> store_strobe_n_o && fetch_pulse_n_o)
    else $error("strobe active during clear");
  clear_recov_a: assert property ($rose(clear_n_o) |->
    (store_strobe_n_o && fetch_pulse_n_o)[*2])
    else $error("strobe too soon after clear");
  clear_width_a: assert property ($fell(clear_n_o) |-> !clear_n_o[*3])
    else $error("clear pulse too short");
  replay_quiet_a: assert property (!replay_n_o |->
    store_strobe_n_o && fetch_pulse_n_o)
    else $error("strobe active during replay");
  replay_width_a: assert property ($fell(replay_n_o) |-> !replay_n_o[*3])
    else $error("replay pulse too short");
  write_pulse_a: assert property ($fell(store_strobe_n_o) |->
    (!store_strobe_n_o && $stable(write_bus_o))[*3])
    else $error("write pulse short or data moved");
  write_allowed_a: assert property ($fell(store_strobe_n_o) |->
    full_flag_n_i && cleared_reg)
    else $error("write to full or uncleared device");
  read_pulse_a: assert property ($fell(fetch_pulse_n_o) |-> !fetch_pulse_n_o[*3])
    else $error("read pulse too short");
  read_allowed_a: assert property ($fell(fetch_pulse_n_o) |-> empty_flag_n_i)
    else $error("read from empty device");
  chain_norep_a: assert property (chain_in_n_o |-> replay_n_o)
    else $error("replay while chained");
endmodule // strobe_fifo_host_properties

// *** dv/strobe_fifo_host_tb.sv ***
// self-checking bench for the strobe fifo host controller
// assumes the device model and checker are compiled first
`timescale 1ns/10ps
`include "strobe_fifo_host_regs.vh"
module strobe_fifo_host_tb;
  localparam int DEPTH = 256;   // device capacity in words
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready, hresp;
  wire  [8:0]  wbus, rbus;
  wire         store_n, fetch_n, clear_n, replay_n, chain_n, first_n, empty_n, full_n, half_n;
  int          n_fail = 0, samples_checked = 0, cyc = 0, rd = 0, i;
  bit          drop = 0, chain = 0;  // model of sticky drop and chain mode
  logic [8:0]  hist[$];              // words written since clear
  logic [31:0] s;
  always #25 clock_i = ~clock_i;
  strobe_fifo_host strobe_fifo_host_i (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .write_bus_o(wbus),
    .read_bus_i(rbus), .store_strobe_n_o(store_n), .fetch_pulse_n_o(fetch_n), .clear_n_o(clear_n),
    .replay_n_o(replay_n), .chain_in_n_o(chain_n), .first_device_n_o(first_n),
    .empty_flag_n_i(empty_n), .full_flag_n_i(full_n), .half_level_n_i(half_n));
  fifo_device_model #(.DEPTH(DEPTH)) fifo_device_model_i (.write_bus_i(wbus),
    .store_strobe_n_i(store_n), .fetch_pulse_n_i(fetch_n), .clear_n_i(clear_n),
    .replay_n_i(replay_n), .chain_in_n_i(chain_n), .read_bus_o(rbus), .empty_flag_n_o(empty_n),
    .full_flag_n_o(full_n), .half_level_n_o(half_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge clock_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  // poll until idle, then compare flags with the model
  task automatic idle;
    logic [31:0] st;
    int n;
    logic [4:0] x;
    n = hist.size() - rd;
    for (int k = 0; k < 50; k++) begin
      bus(`REG_STATUS, 1'b0, 32'h0, st);
      if (st[`ST_BUSY] === 1'b0) break;
    end
    x = {drop, !chain && n > DEPTH / 2, n == DEPTH, n == 0, 1'b0};
    chk({st[5], st[3:0]}, x);
  endtask
  task automatic ctrl(input logic [31:0] v);
    logic [31:0] st;
    bus(`REG_CTRL, 1'b1, v, st);
    if (v[0]) hist.delete();
    if (v[0] || (v[1] && !v[2] && !chain)) rd = 0;
    chain = v[2];
    idle();
  endtask
  task automatic push(input logic [8:0] v);
    logic [31:0] st;
    bus(`REG_WDATA, 1'b1, {23'h0, v}, st);
    if (hist.size() - rd < DEPTH) hist.push_back(v);
    else drop = 1'b1;
    idle();
  endtask
  // first read primes a fetch, second returns the word
  task automatic pop;
    logic [31:0] st;
    logic [8:0]  e;
    e = hist[rd];
    bus(`REG_RDATA, 1'b0, 32'h0, st);
    rd++;
    idle();
    bus(`REG_RDATA, 1'b0, 32'h0, st);
    chk({hresp, st[8:0]}, {1'b0, e});
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ********************
  // hang guard
  // ********************
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 80000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'h56e8152e));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(`REG_WDATA, 1'b1, 32'h1ff, s);
    drop = 1'b1; // write before clear is dropped
    ctrl(32'h1);
    bus(`REG_STATUS, 1'b1, 32'h0, s);
    drop = 1'b0;
    bus(8'h10, 1'b0, 32'h0, s);
    chk(s, 32'h0);
    for (i = 0; i <= DEPTH; i++) push(9'($urandom));
    pop();
    push(9'($urandom));
    while (hist.size() > rd) pop();
    bus(`REG_RDATA, 1'b0, 32'h0, s);
    chk(s, {23'h0, hist[rd - 1]});
    drop = 1'b1; // fetch refused by an empty device is dropped
    idle();
    ctrl(32'h1);
    for (i = 0; i < 3; i++) push(9'($urandom));
    pop();
    pop();
    ctrl(32'h2);
    while (hist.size() > rd) pop();
    ctrl(32'h4);
    chk(chain_n, 1'b1);
    for (i = 0; i <= DEPTH / 2 + 1; i++) push(9'($urandom));
    pop();
    ctrl(32'h6);
    while (hist.size() > rd) pop();
    ctrl(32'h8);
    chk({chain_n, first_n}, 2'h0);
    give_verdict();
  end
endmodule // strobe_fifo_host_tb
bind strobe_fifo_host strobe_fifo_host_properties strobe_fifo_host_properties_i (
  .clock_i(clock_i), .rst_i(rst_i), .write_bus_o(write_bus_o),
  .store_strobe_n_o(store_strobe_n_o), .fetch_pulse_n_o(fetch_pulse_n_o),
  .clear_n_o(clear_n_o), .replay_n_o(replay_n_o), .chain_in_n_o(chain_in_n_o),
  .empty_flag_n_i(empty_flag_n_i), .full_flag_n_i(full_flag_n_i));

// *** include/strobe_fifo_host_regs.vh ***
// constants for the strobe fifo host controller: register offsets, fields, timing
// assumes a 20 MHz clock and a 9-bit asynchronous fifo device on plain pins
//
// Contract
// - host pulses clear before any write
// - strobes stay high around clear release
// - strobes stay high during replay pulse
// - exactly one device marked first loaded
// - host combines flags of chained devices; this host reads the flags of one device only
`ifndef STROBE_FIFO_HOST_REGS_VH
`define STROBE_FIFO_HOST_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_WDATA     8'h08
`define REG_RDATA     8'h0c

// ************************************************************
// fields
// ************************************************************
`define CTRL_CLEAR    0
`define CTRL_REPLAY   1
`define CTRL_CHAIN    2
`define CTRL_FIRST    3
`define CTRL_RESET    4'h0
`define ST_BUSY       0
`define ST_EMPTY      1
`define ST_FULL       2
`define ST_HALF       3
`define ST_RVALID     4
`define ST_DROP       5
`define WORD_W        9

// ************************************************************
// timing (ns, slowest grade) and derived cycle counts at 50 ns
// ************************************************************
`define CLK_NS        50
`define T_PULSE_NS    120
`define T_RECOV_NS    20
`define T_SETUP_NS    120
`define T_ACCESS_NS   120
`define PULSE_CYC     ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOV_CYC     ((`T_RECOV_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC     ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define ACCESS_CYC    ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** logic/strobe_fifo_host.v ***
// host controller driving an asynchronous strobe fifo through its pins
// assumes ahb-lite single word transfers from software and the fifo on device pins
`timescale 1ns/10ps
`include "strobe_fifo_host_regs.vh"

module strobe_fifo_host (
  input  wire        clock_i,
  input  wire        rst_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  // device pins
  output reg  [8:0]  write_bus_o,
  input  wire [8:0]  read_bus_i,
  output reg         store_strobe_n_o,
  output reg         fetch_pulse_n_o,
  output reg         clear_n_o,
  output reg         replay_n_o,
  output reg         chain_in_n_o,
  output reg         first_device_n_o,
  input  wire        empty_flag_n_i,
  input  wire        full_flag_n_i,
  input  wire        half_level_n_i
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [5:0] S_IDLE   = 6'h01;
  localparam [5:0] S_SETUP  = 6'h02;
  localparam [5:0] S_PULSE  = 6'h04;
  localparam [5:0] S_RECOV  = 6'h08;
  localparam [5:0] S_CLEARW = 6'h10;
  localparam [5:0] S_REPW   = 6'h20;
  localparam [1:0] OP_WR = 2'h0;
  localparam [1:0] OP_RD = 2'h1;
  localparam [1:0] OP_CL = 2'h2;
  localparam [1:0] OP_RP = 2'h3;

  reg  [5:0]  state_reg;            // sequencer state
  reg  [1:0]  op_reg;               // operation in flight
  reg  [3:0]  cnt_reg;              // timing counter
  reg  [3:0]  ctrl_reg;             // mode bits
  reg  [8:0]  rdata_reg;            // last fetched word
  reg         rvalid_reg;           // fetched word unread
  reg         drop_reg;             // sticky refused strobe
  reg         cleared_reg;          // a clear has been issued
  reg         pend_reg;             // ahb data phase pending
  reg         pwr_reg;              // pending is write
  reg  [7:0]  paddr_reg;            // pending address
  reg  [8:0]  rb_s1_reg;            // read bus synchroniser
  reg  [8:0]  rb_s2_reg;
  reg  [2:0]  fl_s1_reg;            // flag synchroniser
  reg  [2:0]  fl_s2_reg;

  wire empty_n = fl_s2_reg[0];      // synchronised empty flag
  wire full_n  = fl_s2_reg[1];      // synchronised full flag
  wire half_n  = fl_s2_reg[2];      // synchronised half level
  wire busy    = (state_reg != S_IDLE);
  wire chained = ctrl_reg[`CTRL_CHAIN];

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // two flops before any logic looks at device outputs
  always @(posedge clock_i) begin
    rb_s1_reg <= read_bus_i;
    rb_s2_reg <= rb_s1_reg;
    fl_s1_reg <= {half_level_n_i, full_flag_n_i, empty_flag_n_i};
    fl_s2_reg <= fl_s1_reg;
  end

  // ************************************************************
  // ahb-lite slave: one wait-free data phase, always okay
  // ************************************************************
  wire take = hsel_i & hready_i & htrans_i[1];
  wire [31:0] status_word = {26'h0, drop_reg, rvalid_reg, ~half_n, ~full_n, ~empty_n, busy};
  wire wr_hit  = pend_reg & pwr_reg;
  wire rd_data = pend_reg & ~pwr_reg & (paddr_reg == `REG_RDATA);

  // command decode for the sequencer, only when idle
  wire go_write  = wr_hit & (paddr_reg == `REG_WDATA) & ~busy & cleared_reg;
  wire go_clear  = wr_hit & (paddr_reg == `REG_CTRL) & hwdata_i[`CTRL_CLEAR] & ~busy;
  // replay only from settled single mode, so chain in never lags the replay pin
  wire go_replay = wr_hit & (paddr_reg == `REG_CTRL) & hwdata_i[`CTRL_REPLAY] & ~busy
                   & ~hwdata_i[`CTRL_CHAIN] & ~chained;
  wire go_read   = rd_data & ~busy & ~rvalid_reg;

  always @(posedge clock_i) begin
    if (rst_i) begin
      pend_reg    <= 1'b0;
      pwr_reg     <= 1'b0;
      paddr_reg   <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      ctrl_reg    <= `CTRL_RESET;
    end else begin
      pend_reg  <= take;
      pwr_reg   <= hwrite_i;
      paddr_reg <= haddr_i;
      hresp_o   <= 1'b0;
      hrdata_o  <= 32'h0;
      // register writes land in the data phase
      if (wr_hit) begin
        if (paddr_reg == `REG_CTRL) begin
          ctrl_reg <= hwdata_i[3:0];
        end
      end
      // read data presented one cycle after the address phase
      if (take & ~hwrite_i) begin
        if (haddr_i == `REG_CTRL) begin
          hrdata_o <= {28'h0, ctrl_reg};
        end else if (haddr_i == `REG_STATUS) begin
          hrdata_o <= status_word;
        end else if (haddr_i == `REG_RDATA) begin
          hrdata_o <= {23'h0, rdata_reg};
        end else begin
          hrdata_o <= 32'h0;
        end
      end
    end
  end

  // ************************************************************
  // pin sequencer
  // ************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg        <= S_IDLE;
      op_reg           <= OP_WR;
      cnt_reg          <= 4'h0;
      store_strobe_n_o <= 1'b1;
      fetch_pulse_n_o  <= 1'b1;
      clear_n_o        <= 1'b1;
      replay_n_o       <= 1'b1;
      chain_in_n_o     <= 1'b0;
      first_device_n_o <= 1'b1;
      write_bus_o      <= 9'h000;
      rdata_reg        <= 9'h000;
      rvalid_reg       <= 1'b0;
      drop_reg         <= 1'b0;
      cleared_reg      <= 1'b0;
    end else begin
      // mode pins follow control: chain low means single mode
      chain_in_n_o     <= chained;
      first_device_n_o <= ~ctrl_reg[`CTRL_FIRST];
      // fetched word consumed when software reads it
      if (rd_data & rvalid_reg) begin
        rvalid_reg <= 1'b0;
      end
      // any status write clears the sticky drop; a refusal later in code wins
      if (wr_hit & (paddr_reg == `REG_STATUS)) begin
        drop_reg <= 1'b0;
      end
      // writes refused while busy or before a clear are flagged sticky
      if (wr_hit & (paddr_reg == `REG_WDATA) & (busy | ~cleared_reg)) begin
        drop_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          cnt_reg <= 4'h0;
          if (go_clear) begin
            op_reg    <= OP_CL;
            clear_n_o <= 1'b0;
            state_reg <= S_CLEARW;
          end else if (go_replay) begin
            op_reg     <= OP_RP;
            replay_n_o <= 1'b0;
            state_reg  <= S_REPW;
          end else if (go_write) begin
            if (full_n) begin
              op_reg      <= OP_WR;
              write_bus_o <= hwdata_i[8:0];    // word straight from the data phase
              state_reg   <= S_SETUP;
            end else begin
              drop_reg <= 1'b1;
            end
          end else if (go_read) begin
            if (empty_n) begin
              op_reg          <= OP_RD;
              fetch_pulse_n_o <= 1'b0;
              state_reg       <= S_PULSE;
            end else begin
              drop_reg <= 1'b1;
            end
          end
        end
        S_SETUP: begin
          // data stands before the falling store edge
          store_strobe_n_o <= 1'b0;
          state_reg        <= S_PULSE;
        end
        S_PULSE: begin
          // hold the strobe for the pulse width and data setup
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `PULSE_CYC) begin
            if (op_reg == OP_RD) begin
              rdata_reg       <= rb_s2_reg;
              rvalid_reg      <= 1'b1;
              fetch_pulse_n_o <= 1'b1;
            end else begin
              store_strobe_n_o <= 1'b1;
            end
            cnt_reg   <= 4'h0;
            state_reg <= S_RECOV;
          end
        end
        S_CLEARW, S_REPW: begin
          // strobes stay high; hold the low pulse, then release
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `SETUP_CYC) begin
            clear_n_o   <= 1'b1;
            replay_n_o  <= 1'b1;
            if (op_reg == OP_CL) begin
              cleared_reg <= 1'b1;
              rvalid_reg  <= 1'b0;
            end
            cnt_reg   <= 4'h0;
            state_reg <= S_RECOV;
          end
        end
        S_RECOV: begin
          // recovery plus synchroniser latency so flags are settled
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == (`RECOV_CYC + 3)) begin
            cnt_reg   <= 4'h0;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // strobe_fifo_host
